// ==== rtl/dpp_top.sv ====
// How it works
// - latch selected: data write updates output bits only, inputs untouched
// - latch selected: data read returns live level of all eight lines
// - direction selected: written one makes output, zero makes input
// - direction selected: data read returns stored direction bits
// - data at offsets 04 and 06, control at 05 and 07
// - control bit 7 is read-only pending flag per external line
// - control bit 2 selects latch (1) or direction (0), reads back
// - control bit 1 selects rising (1) or falling (0) edge, reads back
// - control bit 0 enables interrupt from the line, reads back
// - pending clears only on data read with latch selected
//
// Decided for this implementation: strobed register access.
module dpp_top import dpp_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  // first port lines
  input wire logic [7:0] firstLineIn,
  output logic [7:0] firstLineOut,
  output logic [7:0] firstLineOe,
  // second port lines
  input wire logic [7:0] secondLineIn,
  output logic [7:0] secondLineOut,
  output logic [7:0] secondLineOe,
  // external request lines
  input wire logic ext_req_line_first,
  input wire logic ext_req_line_second,
  // interrupt toward host
  output logic irqOut
);
  typedef struct packed {
    logic [1:0][7:0] latch;
    logic [1:0][7:0] dir;
    logic [1:0] latchSel;
    logic [1:0] riseSel;
    logic [1:0] request_gate_on;
    logic [1:0] pend;
    logic [1:0] status;
    logic [1:0] mask;
    logic [7:0] rdata;
  } dpp_top_t;
  dpp_top_t st;
  dpp_top_t next_st;

  logic [15:0] linesSync;
  logic [1:0] reqSync;
  logic [1:0] edgeHit;
  logic [1:0][7:0] linesNow;
  logic [1:0] isData;
  logic [1:0] isCtrl;
  logic [1:0] clrRead;

  dpp_sync #(.WIDTH(16)) u_lines (
    .core_clk(core_clk),
    .rstn(rstn),
    .rawIn({secondLineIn, firstLineIn}),
    .cleanOut(linesSync)
  );
  dpp_sync #(.WIDTH(2)) u_reqs (
    .core_clk(core_clk),
    .rstn(rstn),
    .rawIn({ext_req_line_second, ext_req_line_first}),
    .cleanOut(reqSync)
  );

  assign linesNow[0] = linesSync[7:0];
  assign linesNow[1] = linesSync[15:8];

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_port
      dpp_edge u_edge (
        .core_clk(core_clk),
        .rstn(rstn),
        .lineIn(reqSync[p]),
        .riseSel(st.riseSel[p]),
        .edgeHit(edgeHit[p])
      );
      assign isData[p] = regAddr == (p == 0 ? FIRST_DATA_OFS : SECOND_DATA_OFS);
      assign isCtrl[p] = regAddr == (p == 0 ? FIRST_CTRL_OFS : SECOND_CTRL_OFS);
      assign clrRead[p] = regRead && isData[p] && st.latchSel[p];
    end
  endgenerate

  always_comb begin
    next_st = st;
    next_st.rdata = 8'h00;
    for (int i = 0; i < 2; i++) begin
      if (regWrite && isData[i]) begin
        if (st.latchSel[i]) begin
          // only output bits take the new value
          next_st.latch[i] = (regWdata & st.dir[i]) | (st.latch[i] & ~st.dir[i]);
        end else begin
          next_st.dir[i] = regWdata;
        end
      end
      if (regWrite && isCtrl[i]) begin
        // bits 7..3 are not stored
        next_st.latchSel[i] = regWdata[SEL_BIT];
        next_st.riseSel[i] = regWdata[EDGE_BIT];
        next_st.request_gate_on[i] = regWdata[GATE_BIT];
      end
      // set wins over the read clear
      if (edgeHit[i]) begin
        next_st.pend[i] = 1'b1;
      end else if (clrRead[i]) begin
        next_st.pend[i] = 1'b0;
      end
      if (edgeHit[i] && st.request_gate_on[i]) begin
        next_st.status[i] = 1'b1;
      end else if (regWrite && regAddr == STATUS_OFS && regWdata[i]) begin
        next_st.status[i] = 1'b0;
      end
      if (regRead && isData[i]) begin
        next_st.rdata = st.latchSel[i] ? linesNow[i] : st.dir[i];
      end
      if (regRead && isCtrl[i]) begin
        next_st.rdata = {st.pend[i], 4'h0, st.latchSel[i], st.riseSel[i],
                         st.request_gate_on[i]};
      end
    end
    if (regWrite && regAddr == MASK_OFS) begin
      next_st.mask = regWdata[1:0];
    end
    if (regRead && regAddr == STATUS_OFS) begin
      next_st.rdata = {6'h00, st.status};
    end
    if (regRead && regAddr == MASK_OFS) begin
      next_st.rdata = {6'h00, st.mask};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st.latch <= {LATCH_RESET, LATCH_RESET};
      st.dir <= {DIR_RESET, DIR_RESET};
      st.latchSel <= {CTRL_RESET[SEL_BIT], CTRL_RESET[SEL_BIT]};
      st.riseSel <= {CTRL_RESET[EDGE_BIT], CTRL_RESET[EDGE_BIT]};
      st.request_gate_on <= {CTRL_RESET[GATE_BIT], CTRL_RESET[GATE_BIT]};
      st.pend <= 2'h0;
      st.status <= 2'h0;
      st.mask <= MASK_RESET;
      st.rdata <= 8'h00;
    end else begin
      st <= next_st;
    end
  end

  assign firstLineOut = st.latch[0];
  assign firstLineOe = st.dir[0];
  assign secondLineOut = st.latch[1];
  assign secondLineOe = st.dir[1];
  assign regRdata = st.rdata;
  // host request from pending and enable, plus masked sticky status
  assign irqOut = |(st.pend & st.request_gate_on) | |(st.status & st.mask);

  // data window writes
  input_bits_kept_a: assert property (@(posedge core_clk) disable iff (!rstn)
    regWrite && isData[0] && st.latchSel[0] |=>
      (st.latch[0] & ~$past(st.dir[0])) == ($past(st.latch[0]) & ~$past(st.dir[0])))
    else $error("input bit of latch changed");
  input_kept_two_a: assert property (@(posedge core_clk) disable iff (!rstn)
    regWrite && isData[1] && st.latchSel[1] |=>
      (st.latch[1] & ~$past(st.dir[1])) == ($past(st.latch[1]) & ~$past(st.dir[1])))
    else $error("input bit of second latch changed");
  output_bits_load_a: assert property (@(posedge core_clk) disable iff (!rstn)
    regWrite && isData[1] && st.latchSel[1] |=>
      (st.latch[1] & $past(st.dir[1])) == ($past(regWdata) & $past(st.dir[1])))
    else $error("output bit not loaded");
  output_load_one_a: assert property (@(posedge core_clk) disable iff (!rstn)
    regWrite && isData[0] && st.latchSel[0] |=>
      (st.latch[0] & $past(st.dir[0])) == ($past(regWdata) & $past(st.dir[0])))
    else $error("first output bit not loaded");
  latch_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !(regWrite && isData[0] && st.latchSel[0]) |=> st.latch[0] == $past(st.latch[0]))
    else $error("latch changed without write");

  // direction writes
  dir_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
    regWrite && isData[0] && !st.latchSel[0] |=> firstLineOe == $past(regWdata))
    else $error("direction not written");
  dir_write_two_a: assert property (@(posedge core_clk) disable iff (!rstn)
    regWrite && isData[1] && !st.latchSel[1] |=> secondLineOe == $past(regWdata))
    else $error("second direction not written");
  dir_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !(regWrite && isData[1] && !st.latchSel[1]) |=> secondLineOe == $past(secondLineOe))
    else $error("direction changed without write");

  // reads
  live_read_a: assert property (@(posedge core_clk) disable iff (!rstn)
    regRead && isData[0] && st.latchSel[0] |=> regRdata == $past(linesNow[0]))
    else $error("data read not live level");
  live_read_two_a: assert property (@(posedge core_clk) disable iff (!rstn)
    regRead && isData[1] && st.latchSel[1] |=> regRdata == $past(linesNow[1]))
    else $error("second data read not live level");
  dir_read_a: assert property (@(posedge core_clk) disable iff (!rstn)
    regRead && isData[1] && !st.latchSel[1] |=> regRdata == $past(st.dir[1]))
    else $error("direction read wrong");
  dir_read_one_a: assert property (@(posedge core_clk) disable iff (!rstn)
    regRead && isData[0] && !st.latchSel[0] |=> regRdata == $past(st.dir[0]))
    else $error("first direction read wrong");
  unmapped_read_a: assert property (@(posedge core_clk) disable iff (!rstn)
    regRead && regAddr inside {3'h2, 3'h3} |=> regRdata == 8'h00)
    else $error("unmapped offset read not zero");
  idle_rdata_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !regRead |=> regRdata == 8'h00)
    else $error("read data without read strobe");

  // control registers
  ctrl_read_a: assert property (@(posedge core_clk) disable iff (!rstn)
    regRead && regAddr == FIRST_CTRL_OFS |=> regRdata[6:3] == 4'h0 &&
      regRdata[PEND_BIT] == $past(st.pend[0]) && regRdata[SEL_BIT] == $past(st.latchSel[0]))
    else $error("control read wrong");
  ctrl_read_two_a: assert property (@(posedge core_clk) disable iff (!rstn)
    regRead && regAddr == SECOND_CTRL_OFS |=> regRdata == {$past(st.pend[1]), 4'h0,
      $past(st.latchSel[1]), $past(st.riseSel[1]), $past(st.request_gate_on[1])})
    else $error("second control read wrong");
  ctrl_store_a: assert property (@(posedge core_clk) disable iff (!rstn)
    regWrite && isCtrl[1] |=> st.riseSel[1] == $past(regWdata[EDGE_BIT]) &&
      st.request_gate_on[1] == $past(regWdata[GATE_BIT]))
    else $error("control bits not stored");
  ctrl_store_one_a: assert property (@(posedge core_clk) disable iff (!rstn)
    regWrite && isCtrl[0] |=> st.latchSel[0] == $past(regWdata[SEL_BIT]) &&
      st.request_gate_on[0] == $past(regWdata[GATE_BIT]))
    else $error("first control bits not stored");

  // pending flags
  edge_set_a: assert property (@(posedge core_clk) disable iff (!rstn)
    edgeHit[0] |=> st.pend[0])
    else $error("edge did not set pending");
  edge_set_two_a: assert property (@(posedge core_clk) disable iff (!rstn)
    edgeHit[1] |=> st.pend[1])
    else $error("second edge did not set pending");
  edge_dir_a: assert property (@(posedge core_clk) disable iff (!rstn)
    edgeHit[0] |-> reqSync[0] == st.riseSel[0])
    else $error("edge of wrong polarity");
  edge_dir_two_a: assert property (@(posedge core_clk) disable iff (!rstn)
    edgeHit[1] |-> reqSync[1] == st.riseSel[1])
    else $error("second edge of wrong polarity");
  pend_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
    st.pend[1] && !clrRead[1] |=> st.pend[1])
    else $error("pending lost without read");
  pend_hold_one_a: assert property (@(posedge core_clk) disable iff (!rstn)
    st.pend[0] && !clrRead[0] |=> st.pend[0])
    else $error("first pending lost without read");
  pend_clear_a: assert property (@(posedge core_clk) disable iff (!rstn)
    clrRead[0] && !edgeHit[0] |=> !st.pend[0])
    else $error("pending not cleared");
  pend_clear_two_a: assert property (@(posedge core_clk) disable iff (!rstn)
    clrRead[1] && !edgeHit[1] |=> !st.pend[1])
    else $error("second pending not cleared");

  // request toward the host
  irq_level_a: assert property (@(posedge core_clk) disable iff (!rstn)
    st.pend[1] && st.request_gate_on[1] |-> irqOut)
    else $error("request missing");
  irq_level_one_a: assert property (@(posedge core_clk) disable iff (!rstn)
    st.pend[0] && st.request_gate_on[0] |-> irqOut)
    else $error("first request missing");
  irq_quiet_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !(|(st.pend & st.request_gate_on)) && !(|(st.status & st.mask)) |-> !irqOut)
    else $error("request without cause");
  status_set_a: assert property (@(posedge core_clk) disable iff (!rstn)
    edgeHit[0] && st.request_gate_on[0] |=> st.status[0])
    else $error("status not set");
  status_clear_a: assert property (@(posedge core_clk) disable iff (!rstn)
    regWrite && regAddr == STATUS_OFS && regWdata[1] && !(edgeHit[1] && st.request_gate_on[1])
      |=> !st.status[1])
    else $error("status not cleared");
  status_read_a: assert property (@(posedge core_clk) disable iff (!rstn)
    regRead && regAddr == STATUS_OFS |=> regRdata == {6'h00, $past(st.status)})
    else $error("status read wrong");
  mask_store_a: assert property (@(posedge core_clk) disable iff (!rstn)
    regWrite && regAddr == MASK_OFS |=> st.mask == $past(regWdata[1:0]))
    else $error("mask not stored");

  // reset
  reset_clear_a: assert property (@(posedge core_clk)
    !rstn |=> st.dir == '0 && st.latch == '0 && !irqOut)
    else $error("reset did not clear");
  reset_ctrl_a: assert property (@(posedge core_clk)
    !rstn |=> st.latchSel == 2'h0 && st.riseSel == 2'h0 && st.request_gate_on == 2'h0)
    else $error("reset did not clear control");

  rise_cov: cover property (@(posedge core_clk) disable iff (!rstn)
    edgeHit[0] && st.riseSel[0]);
  fall_cov: cover property (@(posedge core_clk) disable iff (!rstn)
    edgeHit[1] && !st.riseSel[1]);
  clear_cov: cover property (@(posedge core_clk) disable iff (!rstn)
    st.pend[0] ##1 clrRead[0] ##1 !st.pend[0]);
  irq_cov: cover property (@(posedge core_clk) disable iff (!rstn) $rose(irqOut));
  status_cov: cover property (@(posedge core_clk) disable iff (!rstn)
    st.status[1] && st.mask[1]);
endmodule // dpp_top

// ==== rtl/dpp_pkg.sv ====
package dpp_pkg;
  localparam int ADDR_W = 3;
  localparam logic [2:0] FIRST_DATA_OFS = 3'h4;
  localparam logic [2:0] FIRST_CTRL_OFS = 3'h5;
  localparam logic [2:0] SECOND_DATA_OFS = 3'h6;
  localparam logic [2:0] SECOND_CTRL_OFS = 3'h7;
  localparam logic [2:0] STATUS_OFS = 3'h0;
  localparam logic [2:0] MASK_OFS = 3'h1;
  localparam int PEND_BIT = 7;
  localparam int SEL_BIT = 2;
  localparam int EDGE_BIT = 1;
  localparam int GATE_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [1:0] MASK_RESET = 2'h0;
  // cycles after reset before the filtered request line is trusted
  localparam logic [2:0] EDGE_WARMUP = 3'h5;
endpackage

// ==== rtl/dpp_sync.sv ====
module dpp_sync import dpp_pkg::*; #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // raw and filtered levels
  input wire logic [WIDTH-1:0] rawIn,
  output logic [WIDTH-1:0] cleanOut
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] stable;
  } dpp_sync_t;
  dpp_sync_t st;
  dpp_sync_t next_st;
  generate
    if (WIDTH < 1) begin : g_chk
      $error("dpp_sync width must be positive");
    end
  endgenerate
  always_comb begin
    next_st = st;
    next_st.s1 = rawIn;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < WIDTH; i++) begin
      // change counts once stage two and three agree
      if (st.s2[i] == st.s3[i]) begin
        next_st.stable[i] = st.s3[i];
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign cleanOut = st.stable;
endmodule // dpp_sync

// ==== rtl/dpp_edge.sv ====
module dpp_edge import dpp_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // filtered line and edge choice
  input wire logic lineIn,
  input wire logic riseSel,
  // one-cycle edge pulse
  output logic edgeHit
);
  typedef struct packed {
    logic prev;
    logic [2:0] warm;
  } dpp_edge_t;
  dpp_edge_t st;
  dpp_edge_t next_st;
  always_comb begin
    next_st.prev = lineIn;
    next_st.warm = st.warm;
    if (st.warm != EDGE_WARMUP) begin
      next_st.warm = 3'(st.warm + 3'h1);
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  // no edge until the synchroniser has settled, so a line idling high gives no false edge
  assign edgeHit = (st.warm == EDGE_WARMUP) &&
                   (riseSel ? (lineIn && !st.prev) : (!lineIn && st.prev));
endmodule // dpp_edge

// ==== tb/dpp_far_side.sv ====
module dpp_far_side (
  // pin drive from the block
  input wire logic [7:0] firstLineOut,
  input wire logic [7:0] firstLineOe,
  input wire logic [7:0] secondLineOut,
  input wire logic [7:0] secondLineOe,
  // outside levels set by the bench
  input wire logic [7:0] firstExt,
  input wire logic [7:0] secondExt,
  input wire logic [1:0] reqLevel,
  // resolved pin levels
  output logic [7:0] firstLineIn,
  output logic [7:0] secondLineIn,
  output logic ext_req_line_first,
  output logic ext_req_line_second
);
  timeunit 1ns;
  timeprecision 1ps;
  // driven bits win, released bits follow the outside
  assign firstLineIn = (firstLineOe & firstLineOut) | (~firstLineOe & firstExt);
  assign secondLineIn = (secondLineOe & secondLineOut) | (~secondLineOe & secondExt);
  assign ext_req_line_first = reqLevel[0];
  assign ext_req_line_second = reqLevel[1];
endmodule // dpp_far_side

// ==== tb/tb.sv ====
`define CHK(a, b) begin nChecks++; if ((a) !== (b)) begin errCount++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end
module tb import dpp_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rstn, regWrite, regRead, irqOut, reqFirst, reqSecond;
  logic [ADDR_W-1:0] regAddr;
  logic [7:0] regWdata, regRdata, firstLineIn, firstLineOut, firstLineOe;
  logic [7:0] secondLineIn, secondLineOut, secondLineOe, firstExt, secondExt;
  logic [1:0] reqLevel;
  int errCount, nChecks;
  dpp_top uut (.core_clk(core_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .firstLineIn(firstLineIn),
    .firstLineOut(firstLineOut), .firstLineOe(firstLineOe), .secondLineIn(secondLineIn),
    .secondLineOut(secondLineOut), .secondLineOe(secondLineOe),
    .ext_req_line_first(reqFirst), .ext_req_line_second(reqSecond), .irqOut(irqOut));
  dpp_far_side far (.firstLineOut(firstLineOut), .firstLineOe(firstLineOe),
    .secondLineOut(secondLineOut), .secondLineOe(secondLineOe), .firstExt(firstExt),
    .secondExt(secondExt), .reqLevel(reqLevel), .firstLineIn(firstLineIn),
    .secondLineIn(secondLineIn), .ext_req_line_first(reqFirst),
    .ext_req_line_second(reqSecond));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    @(negedge core_clk);
    `CHK(regRdata & m, e)
  endtask
  task automatic t_reset;
    rd(FIRST_CTRL_OFS, CTRL_RESET, 8'hff);
    rd(SECOND_CTRL_OFS, CTRL_RESET, 8'hff);
    rd(FIRST_DATA_OFS, DIR_RESET, 8'hff);
    rd(SECOND_DATA_OFS, DIR_RESET, 8'hff);
    `CHK({firstLineOe, secondLineOe, firstLineOut, secondLineOut, irqOut}, 33'h0)
    wr(3'h3, 8'hff);
    rd(3'h3, 8'h00, 8'hff);
    $display("test reset done");
  endtask
  task automatic t_port(input int p);
    logic [2:0] d, c;
    logic [7:0] ext;
    d = p ? SECOND_DATA_OFS : FIRST_DATA_OFS;
    c = p ? SECOND_CTRL_OFS : FIRST_CTRL_OFS;
    ext = p ? secondExt : firstExt;
    wr(c, 8'h00);
    wr(d, 8'h0f);
    rd(d, 8'h0f, 8'hff);
    wr(c, 8'h04);
    rd(c, 8'h04, 8'hff);
    wr(d, 8'ha5);
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    `CHK(p ? {secondLineOe, secondLineOut[3:0]} : {firstLineOe, firstLineOut[3:0]}, 12'h0f5)
    rd(d, {ext[7:4], 4'h5}, 8'hff);
    // input bits of the latch kept their reset zeros
    wr(c, 8'h00);
    wr(d, 8'hff);
    @(negedge core_clk);
    `CHK(p ? secondLineOut : firstLineOut, 8'h05)
    wr(d, 8'h0f);
    $display("test port %0d done", p);
  endtask
  task automatic t_irq(input int p);
    logic [2:0] d, c;
    logic [7:0] m;
    d = p ? SECOND_DATA_OFS : FIRST_DATA_OFS;
    c = p ? SECOND_CTRL_OFS : FIRST_CTRL_OFS;
    for (int k = 0; k < 4; k++) begin
      m = {6'h0, k[0], k[1]};
      @(posedge core_clk) reqLevel[p] <= ~k[0];
      repeat (8) @(posedge core_clk);
      wr(c, 8'h04 | m);
      rd(d, 8'h00, 8'h00);
      @(posedge core_clk) reqLevel[p] <= k[0];
      repeat (8) @(posedge core_clk);
      rd(c, 8'h84 | m, 8'hff);
      `CHK(irqOut, k[1])
      wr(c, m);
      rd(d, 8'h0f, 8'hff);
      rd(c, 8'h80 | m, 8'hff);
      wr(c, 8'h04 | m);
      rd(d, 8'h00, 8'h00);
      rd(c, 8'h04 | m, 8'hff);
      `CHK(irqOut, 1'b0)
      @(posedge core_clk) reqLevel[p] <= ~k[0];
      repeat (8) @(posedge core_clk);
      rd(c, 8'h04 | m, 8'hff);
    end
    $display("test irq %0d done", p);
  endtask
  task automatic t_mask;
    rd(STATUS_OFS, 8'h03, 8'hff);
    wr(MASK_OFS, 8'h03);
    rd(MASK_OFS, 8'h03, 8'h03);
    `CHK(irqOut, 1'b1)
    wr(STATUS_OFS, 8'h01);
    rd(STATUS_OFS, 8'h02, 8'hff);
    `CHK(irqOut, 1'b1)
    wr(MASK_OFS, 8'h01);
    @(negedge core_clk);
    `CHK(irqOut, 1'b0)
    wr(STATUS_OFS, 8'h02);
    rd(STATUS_OFS, 8'h00, 8'hff);
    $display("test mask done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    {rstn, regWrite, regRead, regAddr, regWdata, reqLevel} = '0;
    firstExt = 8'hc3;
    secondExt = 8'h5a;
    errCount = 0;
    nChecks = 0;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    t_reset;
    t_port(0);
    t_port(1);
    t_irq(0);
    t_irq(1);
    t_mask;
    // second reset in mid-run must clear everything again
    @(posedge core_clk) rstn <= 1'b0;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    t_reset;
    results;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    $display("Error %0t: run did not finish", $time);
    errCount++;
    results;
  end
endmodule // tb
